// ===== verilog/pfb_pkg.sv
// constants and types for the program flow trace buffer
package pfb_pkg;

  // storage depth and count field
  localparam int          DEPTH_DEF = 16;
  localparam int          CNT_W     = 5;

  // register byte addresses
  localparam logic [31:0] ADDR_CONTROL   = 32'hffe06000;
  localparam logic [31:0] ADDR_STATUS    = 32'hffe06004;
  localparam logic [31:0] ADDR_READ_PORT = 32'hffe06008;

  // trace_control fields
  localparam int          CTL_W        = 5;
  localparam int          CTL_POWER    = 0;
  localparam int          CTL_ENABLE   = 1;
  localparam int          CTL_OVF      = 2;
  localparam int          CTL_COMP_LO  = 3;
  localparam int          CTL_COMP_HI  = 4;
  localparam logic [4:0]  CTL_RESET    = 5'h00;

  // trace_status field
  localparam int          STAT_CNT_HI  = 4;

  // compression modes
  localparam logic [1:0]  COMP_NONE    = 2'h0;
  localparam logic [1:0]  COMP_SINGLE  = 2'h1;
  localparam logic [1:0]  COMP_TWO     = 2'h2;

  // discontinuity report from the program sequencer
  typedef struct packed {
    logic        valid;
    logic        hwLoop;
    logic        excLevel;
    logic        emuMode;
    logic [31:0] source;
    logic [31:0] target;
  } pfb_flow_type;

  // one stored discontinuity
  typedef struct packed {
    logic [31:0] source;
    logic [31:0] target;
    logic        singleSeen;
    logic        twoSeen;
  } pfb_entry_type;

  // bus slave phase
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } pfb_bus_type;

endpackage

// ===== verilog/pfb_trace_buffer.sv
// program flow trace buffer with an AHB-Lite register slave
// Notes on behaviour
// - keep the newest sixteen flow discontinuities
// - each entry holds source and target
// - hardware loop flow changes never stored
// - compression drops repeats of newest entries
// - read port gives target, then source
// - count drops after every second read
// - status bits four to zero hold count
// - single compression sets target bit zero
// - two-level compression sets source bit zero
// - record only when powered and enabled
// - overflow raises exception only when enabled
// - overflow mode skips exception level handlers
// - nothing recorded in emulator mode
`timescale 1ns/1ps

module pfb_trace_buffer #(
  parameter int DEPTH = pfb_pkg::DEPTH_DEF
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire pfb_pkg::pfb_flow_type flowIn,
  output logic                      overflowExc
);

  // the count field is five bits wide, so it cannot name more than 31 entries
  if (DEPTH < 2 || DEPTH >= (1 << pfb_pkg::CNT_W))
  begin : g_bad_depth
    $error("DEPTH must lie between 2 and 31");
  end

  localparam logic [pfb_pkg::CNT_W-1:0] FULL = (pfb_pkg::CNT_W)'(DEPTH);

  function automatic logic sameFlow(input pfb_pkg::pfb_entry_type e,
                                    input pfb_pkg::pfb_flow_type f);
    sameFlow = (e.source == f.source) && (e.target == f.target);
  endfunction

  function automatic logic [31:0] zeroExtCount(input logic [pfb_pkg::CNT_W-1:0] c);
    zeroExtCount = {{(32 - pfb_pkg::CNT_W){1'b0}}, c};
  endfunction

  pfb_pkg::pfb_bus_type             busState_q;
  pfb_pkg::pfb_bus_type             busState_d;
  logic [31:0]                      addr_q;
  logic                             write_q;
  logic                             readyOut_q;
  logic [31:0]                      hrdata_q;
  logic [pfb_pkg::CTL_W-1:0]        control_q;
  logic [pfb_pkg::CNT_W-1:0]        count_q;
  logic [pfb_pkg::CNT_W-1:0]        count_d;
  logic                             half_q;
  logic                             pendSingle_q;
  logic                             pendTwo_q;
  logic                             exc_q;
  pfb_pkg::pfb_entry_type           entries [DEPTH];

  // bus decode
  wire addrPhase = hsel & htrans[1] & hready;
  wire inData    = (busState_q == pfb_pkg::BUS_DATA);
  wire notEmpty  = (count_q != '0);
  wire rdPort    = inData & ~write_q & (addr_q == pfb_pkg::ADDR_READ_PORT) & notEmpty;
  wire ctlWr     = inData & write_q & (addr_q == pfb_pkg::ADDR_CONTROL);
  wire popNow    = rdPort & half_q;

  // control fields
  wire       powerOn  = control_q[pfb_pkg::CTL_POWER];
  wire       recordEn = control_q[pfb_pkg::CTL_ENABLE];
  wire       ovfExcEn = control_q[pfb_pkg::CTL_OVF];
  wire [1:0] compMode = control_q[pfb_pkg::CTL_COMP_HI:pfb_pkg::CTL_COMP_LO];

  // recording gate; a pop in the same cycle wins so no read is lost
  wire allowed = flowIn.valid & powerOn & recordEn
               & ~flowIn.hwLoop
               & ~flowIn.emuMode
               & ~(ovfExcEn & flowIn.excLevel)
               & ~popNow;

  // compression compares only against valid entries
  wire hit0       = notEmpty & sameFlow(entries[0], flowIn);
  wire hit1       = (count_q > 5'h01) & sameFlow(entries[1], flowIn);
  wire compOn     = (compMode == pfb_pkg::COMP_SINGLE) | (compMode == pfb_pkg::COMP_TWO);
  wire dropSingle = allowed & compOn & hit0;
  wire dropTwo    = allowed & (compMode == pfb_pkg::COMP_TWO) & ~hit0 & hit1;
  wire push       = allowed & ~dropSingle & ~dropTwo;
  wire full       = (count_q == FULL);

  // new entry carries the markers of compression seen since last store
  pfb_pkg::pfb_entry_type newEntry;
  assign newEntry.source     = flowIn.source;
  assign newEntry.target     = flowIn.target;
  assign newEntry.singleSeen = pendSingle_q | dropSingle;
  assign newEntry.twoSeen    = pendTwo_q | dropTwo;

  // read port word: target first, then source, markers in bit zero
  wire [31:0] tgtWord  = {entries[0].target[31:1],
                          entries[0].target[0] | entries[0].singleSeen};
  wire [31:0] srcWord  = {entries[0].source[31:1],
                          entries[0].source[0] | entries[0].twoSeen};
  wire [31:0] portWord = !notEmpty ? 32'h00000000 : (half_q ? srcWord : tgtWord);

  wire [31:0] ctlWord  = {{(32 - pfb_pkg::CTL_W){1'b0}}, control_q};
  wire [31:0] statWord = zeroExtCount(count_q);
  wire [31:0] readMux  = (addr_q == pfb_pkg::ADDR_CONTROL)   ? ctlWord  :
                         (addr_q == pfb_pkg::ADDR_STATUS)    ? statWord :
                         (addr_q == pfb_pkg::ADDR_READ_PORT) ? portWord :
                         32'h00000000;

  // count: full without exception keeps its maximum as the oldest is lost
  always_comb
  begin
    count_d = count_q;
    if (push && !full)
      count_d = count_q + 5'h01;
    else if (popNow)
      count_d = count_q - 5'h01;
  end

  // a new address phase may follow a data phase directly when another slave drives hready
  always_comb
  begin
    case (busState_q)
      pfb_pkg::BUS_IDLE:
        busState_d = addrPhase ? pfb_pkg::BUS_DATA : pfb_pkg::BUS_IDLE;
      pfb_pkg::BUS_DATA:
        busState_d = addrPhase ? pfb_pkg::BUS_DATA : pfb_pkg::BUS_IDLE;
      default:
        busState_d = pfb_pkg::BUS_IDLE;
    endcase
  end

  // bus slave: every transfer takes one wait state so hrdata comes from a flop
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busState_q <= pfb_pkg::BUS_IDLE;
      addr_q     <= 32'h00000000;
      write_q    <= 1'b0;
      readyOut_q <= 1'b1;
    end
    else
    begin
      busState_q <= busState_d;
      readyOut_q <= ~addrPhase;
      if (addrPhase)
      begin
        addr_q  <= haddr;
        write_q <= hwrite;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata_q <= 32'h00000000;
    else if (inData && !write_q)
      hrdata_q <= readMux;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      control_q <= pfb_pkg::CTL_RESET;
    else if (ctlWr)
      control_q <= hwdata[pfb_pkg::CTL_W-1:0];
  end

  // trace state
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q      <= 5'h00;
      half_q       <= 1'b0;
      pendSingle_q <= 1'b0;
      pendTwo_q    <= 1'b0;
      exc_q        <= 1'b0;
    end
    else
    begin
      count_q      <= count_d;
      half_q       <= half_q ^ rdPort;
      pendSingle_q <= dropSingle | (pendSingle_q & ~push);
      pendTwo_q    <= dropTwo | (pendTwo_q & ~push);
      exc_q        <= push & full & ovfExcEn;
    end
  end

  // newest entry sits at index zero; no reset since count marks validity
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      for (int i = DEPTH - 1; i > 0; i--)
        entries[i] <= entries[i-1];
      entries[0] <= newEntry;
    end
    else if (popNow)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
        entries[i] <= entries[i+1];
    end
  end

  assign hrdata      = hrdata_q;
  assign hreadyout   = readyOut_q;
  assign hresp       = 1'b0;
  assign overflowExc = exc_q;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence sPortRead;
    inData && !write_q && addr_q == pfb_pkg::ADDR_READ_PORT && notEmpty;
  endsequence

  a_loop_not_stored: assert property (
    flowIn.valid && flowIn.hwLoop && !popNow |=> count_q == $past(count_q))
    else $error("hardware loop change was stored");

  a_emu_not_stored: assert property (
    flowIn.valid && flowIn.emuMode && !popNow |=> count_q == $past(count_q))
    else $error("emulator mode change was stored");

  a_gate_off_hold: assert property (
    !(powerOn && recordEn) && !popNow |=> count_q == $past(count_q))
    else $error("recorded while trace off");

  a_count_bounded: assert property (
    count_q <= FULL)
    else $error("count above depth");

  a_read_target_first: assert property (
    sPortRead and !half_q |=> hrdata == $past(tgtWord))
    else $error("first read did not return target");

  a_pop_every_second: assert property (
    sPortRead and half_q and !push |=> count_q == $past(count_q) - 5'h01)
    else $error("count did not drop on second read");

  a_first_read_keeps: assert property (
    sPortRead and !half_q and !push |=> count_q == $past(count_q))
    else $error("count dropped on first read");

  sequence sOverflowPush;
    push && full && ovfExcEn;
  endsequence

  sequence sExcPulse;
    overflowExc ##1 (!overflowExc || $past(push && full && ovfExcEn));
  endsequence

  a_overflow_raises: assert property (
    sOverflowPush |=> sExcPulse)
    else $error("overflow exception missing");

  a_overflow_ignored: assert property (
    !ovfExcEn |=> !overflowExc)
    else $error("exception raised while ignored");

  a_full_replace: assert property (
    push && full |=> count_q == FULL)
    else $error("full buffer lost its count");

  a_handler_skipped: assert property (
    flowIn.valid && flowIn.excLevel && ovfExcEn && !popNow |=> count_q == $past(count_q))
    else $error("handler change was stored");

  a_single_drop: assert property (
    dropSingle |=> count_q == $past(count_q) && pendSingle_q)
    else $error("single compression did not drop");

  a_status_count: assert property (
    inData && !write_q && addr_q == pfb_pkg::ADDR_STATUS |=> hrdata == zeroExtCount($past(count_q)))
    else $error("status does not show count");

  a_push_grows: assert property (
    push && !full |=> count_q == $past(count_q) + 5'h01)
    else $error("stored change did not raise count");

  a_newest_on_top: assert property (
    push |=> entries[0].source == $past(flowIn.source)
             && entries[0].target == $past(flowIn.target))
    else $error("newest entry does not hold the pair");

  a_full_shift: assert property (
    push && full |=> entries[1] == $past(entries[0]))
    else $error("full buffer did not move its entries");

  a_comp_off_stores: assert property (
    allowed && !full && compMode != pfb_pkg::COMP_SINGLE && compMode != pfb_pkg::COMP_TWO
    |=> count_q == $past(count_q) + 5'h01)
    else $error("change dropped with compression off");

  a_two_drop: assert property (
    dropTwo |=> count_q == $past(count_q) && pendTwo_q)
    else $error("two level compression did not drop");

  a_read_source_second: assert property (
    sPortRead and half_q |=> hrdata == $past(srcWord))
    else $error("second read did not return source");

  a_target_marker: assert property (
    sPortRead and !half_q and entries[0].singleSeen |=> hrdata[0])
    else $error("target marker bit missing");

  a_source_marker: assert property (
    sPortRead and half_q and entries[0].twoSeen |=> hrdata[0])
    else $error("source marker bit missing");

  a_single_carried: assert property (
    push && pendSingle_q |=> entries[0].singleSeen)
    else $error("single marker not carried");

  a_two_carried: assert property (
    push && pendTwo_q |=> entries[0].twoSeen)
    else $error("two level marker not carried");

  a_pend_cleared: assert property (
    push |=> !pendSingle_q && !pendTwo_q)
    else $error("marker still pending after store");

  a_control_write: assert property (
    ctlWr |=> control_q == $past(hwdata[pfb_pkg::CTL_W-1:0]))
    else $error("control write lost");

  a_pop_shift: assert property (
    popNow && count_q > 5'h01 |=> entries[0] == $past(entries[1]))
    else $error("drained entry not replaced by next");

endmodule

// ===== verif/pfb_flow_model.sv
// program sequencer model that drives discontinuity reports
`timescale 1ns/1ps
module pfb_flow_model (
  input  wire logic             ref_clk,
  output pfb_pkg::pfb_flow_type flowIn
);
  initial flowIn = '0;
  // q is {hwLoop, excLevel, emuMode}; back to back calls give back to back reports
  task automatic push(input logic [31:0] s, input logic [31:0] t, input logic [2:0] q);
    @(posedge ref_clk);
    flowIn <= {1'b1, q, s, t};
  endtask
  // payload flips when idle so a stale address never passes for a live one
  task automatic idle();
    @(posedge ref_clk);
    flowIn <= {1'b0, 3'h0, ~flowIn.source, ~flowIn.target};
  endtask
endmodule

// ===== verif/program_flow_trace_buffer_test.sv
// self-checking bench for the program flow trace buffer
`timescale 1ns/1ps
module program_flow_trace_buffer_test;
  localparam int          N    = 4;
  localparam logic [31:0] CTL  = pfb_pkg::ADDR_CONTROL;
  localparam logic [31:0] STA  = pfb_pkg::ADDR_STATUS;
  localparam logic [31:0] PORT = pfb_pkg::ADDR_READ_PORT;
  logic                  ref_clk = 1'b0;
  logic                  rst_n   = 1'b0;
  logic [31:0]           haddr   = '0;
  logic [1:0]            htrans  = 2'h0;
  logic                  hwrite  = 1'b0;
  logic [31:0]           hwdata  = '0;
  logic [31:0]           hrdata;
  logic                  hreadyout;
  logic                  hresp;
  logic                  overflowExc;
  logic                  rdPend  = 1'b0;
  logic [31:0]           rnd     = 32'h01523857;
  logic [31:0]           s[6];
  logic [31:0]           t[6];
  logic [31:0]           expQ[$];
  int                    miscompares = 0;
  int                    checks      = 0;
  int                    excSeen     = 0;
  pfb_pkg::pfb_flow_type flow;

  always #10 ref_clk = ~ref_clk;

  // small depth keeps the fill and overflow cases short
  pfb_trace_buffer #(.DEPTH(N)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flowIn(flow),
    .overflowExc(overflowExc)
  );
  pfb_flow_model fm (.ref_clk(ref_clk), .flowIn(flow));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic cmp32(input string n, input logic [31:0] e, input logic [31:0] a);
    checks++;
    if (a !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, a);
    end
  endtask

  task automatic cmpCnt(input string n, input int e, input int a);
    checks++;
    if (a != e)
    begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", n, e, a);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ready is sampled at the rising edge, before that edge updates it
  task automatic waitReady();
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    waitReady();
    htrans <= 2'h0;
    hwdata <= d;
    rdPend <= !w;
    waitReady();
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    expQ.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask

  task automatic pair(input int i, input logic tb, input logic sb);
    rd(PORT, t[i] | {31'h0, tb});
    rd(PORT, s[i] | {31'h0, sb});
  endtask

  task automatic pushN(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) fm.push(s[i], t[i], 3'h0);
  endtask

  always @(negedge ref_clk)
  begin
    if (overflowExc !== 1'b0) excSeen++;
    if (rdPend && hreadyout === 1'b1)
    begin
      cmp32("hrdata", expQ.pop_front(), hrdata);
      cmp32("hresp", 32'h0, {31'h0, hresp});
      rdPend = 1'b0;
    end
  end

  initial
  begin
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      s[i] = rnd & 32'hfffffffe;
      rnd = lfsr(rnd);
      t[i] = rnd & 32'hfffffffe;
    end
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(CTL, 32'h0);
    rd(STA, 32'h0);
    rd(PORT, 32'h0);
    rd(32'hffe0600c, 32'h0);
    $display("test reset done");
    wr_rec: begin
      ahb(1'b1, CTL, 32'h3);
      pushN(0, 1);
      fm.push(s[2], t[2], 3'h4);
      fm.push(s[3], t[3], 3'h1);
      fm.push(s[4], t[4], 3'h2);
      fm.idle();
      ahb(1'b1, STA, 32'h1f);
      rd(STA, 32'h3);
      // the sequencer model stays idle while the port is drained
      pair(4, 1'b0, 1'b0);
      rd(STA, 32'h2);
      pair(1, 1'b0, 1'b0);
      pair(0, 1'b0, 1'b0);
      rd(STA, 32'h0);
      rd(PORT, 32'h0);
    end
    $display("test record done");
    for (int m = 1; m <= 2; m++)
    begin
      ahb(1'b1, CTL, 32'(m));
      fm.push(s[0], t[0], 3'h0);
      fm.idle();
      rd(STA, 32'h0);
    end
    $display("test gate done");
    ahb(1'b1, CTL, 32'h0b);
    fm.push(s[0], t[0], 3'h0);
    pushN(0, 1);
    fm.idle();
    rd(STA, 32'h2);
    pair(1, 1'b1, 1'b0);
    pair(0, 1'b0, 1'b0);
    ahb(1'b1, CTL, 32'h13);
    pushN(0, 1);
    fm.push(s[0], t[0], 3'h0);
    fm.push(s[2], t[2], 3'h0);
    fm.idle();
    rd(STA, 32'h3);
    pair(2, 1'b0, 1'b1);
    pair(1, 1'b0, 1'b0);
    pair(0, 1'b0, 1'b0);
    ahb(1'b1, CTL, 32'h1b);
    fm.push(s[3], t[3], 3'h0);
    fm.push(s[3], t[3], 3'h0);
    fm.idle();
    rd(STA, 32'h2);
    pair(3, 1'b0, 1'b0);
    pair(3, 1'b0, 1'b0);
    $display("test compress done");
    ahb(1'b1, CTL, 32'h3);
    pushN(0, N);
    fm.idle();
    rd(STA, 32'(N));
    for (int i = N; i >= 1; i--) pair(i, 1'b0, 1'b0);
    cmpCnt("overflowExc", 0, excSeen);
    ahb(1'b1, CTL, 32'h7);
    pushN(0, N);
    fm.push(s[5], t[5], 3'h2);
    fm.idle();
    rd(STA, 32'(N));
    cmpCnt("overflowExc", 1, excSeen);
    for (int i = N; i >= 1; i--) pair(i, 1'b0, 1'b0);
    $display("test overflow done");
    pushN(0, 1);
    fm.idle();
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(STA, 32'h0);
    rd(CTL, 32'h0);
    rd(PORT, 32'h0);
    $display("test reset again done");
    stop_test();
  end
endmodule
